// ### design/iocf_out_chan.sv
// One output channel: gate, fallback mode and predefined state.
// Assumes the mode signals come from the owning block's state machine.
`timescale 1ns/1ps
`default_nettype none
module iocf_out_chan
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Mode
	input wire logic fallback,
	input wire logic freeze,
	// Channel settings
	input wire logic cmd,
	input wire logic gate,
	input wire logic fb_mode,
	input wire logic fb_state,
	// Pin drive
	output logic q
);
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			q <= 1'b0;
		else if (freeze)
			q <= q; // RULE13
		else if (fallback)
		begin
			if (fb_mode)
				q <= fb_state; // RULE10
			else
				q <= q; // RULE9
		end
		else if (gate)
			q <= cmd; // RULE11 RULE16
	end
endmodule
`default_nettype wire

// ### design/iocf_pkg.sv
// Package for the channel configuration and fallback block.
// Assumes a 32-bit APB slave at 100 MHz; offsets are byte addresses.
package iocf_pkg;
	localparam int IOCF_CHANNELS = 8;
	localparam int IOCF_IMAGE_WORDS = 8;
	localparam logic [7:0] IOCF_ADDR_PRI_DIR = 8'h00;
	localparam logic [7:0] IOCF_ADDR_SEC_DIR = 8'h04;
	localparam logic [7:0] IOCF_ADDR_DIAG_SEL = 8'h08;
	localparam logic [7:0] IOCF_ADDR_IN_MASK = 8'h0C;
	localparam logic [7:0] IOCF_ADDR_FB_MODE = 8'h10;
	localparam logic [7:0] IOCF_ADDR_FB_STATE = 8'h14;
	localparam logic [7:0] IOCF_ADDR_OUT_GATE = 8'h18;
	localparam logic [7:0] IOCF_ADDR_OUT_CMD = 8'h1C;
	localparam logic [7:0] IOCF_ADDR_STATUS = 8'h20;
	localparam logic [7:0] IOCF_ADDR_IMAGE = 8'h40;
	localparam logic [7:0] IOCF_RST_PRI_DIR = 8'h00;
	localparam logic [7:0] IOCF_RST_SEC_DIR = 8'h00;
	localparam logic [7:0] IOCF_RST_DIAG_SEL = 8'hFF;
	localparam logic [7:0] IOCF_RST_IN_MASK = 8'h00;
	localparam logic [7:0] IOCF_RST_FB_MODE = 8'hFF;
	localparam logic [7:0] IOCF_RST_FB_STATE = 8'h00;
	localparam logic [7:0] IOCF_RST_OUT_GATE = 8'hFF;
	localparam logic [7:0] IOCF_RST_OUT_CMD = 8'h00;
	localparam int IOCF_STAT_FALLBACK = 0;
	localparam int IOCF_STAT_FREEZE = 1;
	typedef enum logic [2:0]
	{
		IOCF_RUN = 3'b001,
		IOCF_FALLBACK = 3'b010,
		IOCF_FREEZE = 3'b100
	} iocf_mode_e;
endpackage

// ### design/iocf_top.sv
// Channel configuration, input masking and output fallback for an 8-socket box.
// Assumes APB from the network interface side and synchronous pin inputs.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1: Primary direction bit 1 drives output.
// RULE2: Secondary input needs diag 0, dir 0.
// RULE3: Secondary pin reports diagnostics by default.
// RULE4: Diag select resets 1; 0 drops diagnostics.
// RULE5: Mask bit 1 ignores that input.
// RULE6: Mask also gates diagnostic reporting.
// RULE7: Link loss forces per-channel fallback values.
// RULE8: Fallback mode resets 1, predefined state.
// RULE9: Hold mode keeps last output value.
// RULE10: Predefined mode drives fallback bit, reset 0.
// RULE11: Gate 0 holds output, ignores commands.
// RULE12: System events also trigger fallback.
// RULE13: Online stop freezes all outputs.
// RULE14: Image is eight 16-bit words, inputs first.
// RULE15: Partner places image by node address.
// RULE16: Restored link resumes gated commands.
module iocf_top
	import iocf_pkg::*;
#(
	parameter int CH = iocf_pkg::IOCF_CHANNELS
)
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Fallback events and online stop
	input wire logic link_lost,
	input wire logic netif_fail,
	input wire logic cable_off,
	input wire logic cfg_download,
	input wire logic cfg_reset,
	input wire logic cfg_store,
	input wire logic cfg_stop,
	// Primary pins
	input wire logic [CH-1:0] pri_in,
	output logic [CH-1:0] pri_out,
	output logic [CH-1:0] pri_oe,
	// Secondary pins
	input wire logic [CH-1:0] sec_in,
	output logic [CH-1:0] sec_out,
	output logic [CH-1:0] sec_oe,
	// Diagnostic sources
	input wire logic [CH-1:0] diag_in,
	// Status
	output logic fallback_active
);
	import iocf_pkg::*;

	logic [7:0] pri_dir_r;
	logic [7:0] sec_dir_r;
	logic [7:0] diag_sel_r;
	logic [7:0] in_mask_r;
	logic [7:0] fb_mode_r;
	logic [7:0] fb_state_r;
	logic [7:0] out_gate_r;
	logic [7:0] pri_cmd_r;
	logic [7:0] sec_cmd_r;
	logic [15:0] image_r [IOCF_IMAGE_WORDS];
	iocf_mode_e mode_r;
	iocf_mode_e mode_nxt;
	logic [CH-1:0] pri_q;
	logic [CH-1:0] sec_q;
	logic [CH-1:0] sec_is_in;
	logic [CH-1:0] sec_is_out;
	logic wr_en;
	logic rd_en;
	logic fb_event;
	logic [31:0] rd_nxt;
	logic addr_ok;

	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign fb_event = link_lost | netif_fail | cable_off | cfg_download | cfg_reset | cfg_store; // RULE7 RULE12
	assign sec_is_in = ~diag_sel_r & ~sec_dir_r; // RULE2
	assign sec_is_out = ~diag_sel_r & sec_dir_r;

	// Configuration registers; reset values leave every socket as a diagnosed input
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pri_dir_r <= IOCF_RST_PRI_DIR;
			sec_dir_r <= IOCF_RST_SEC_DIR; // RULE2
			diag_sel_r <= IOCF_RST_DIAG_SEL; // RULE3 RULE4
			in_mask_r <= IOCF_RST_IN_MASK; // RULE5
			fb_mode_r <= IOCF_RST_FB_MODE; // RULE8
			fb_state_r <= IOCF_RST_FB_STATE; // RULE10
			out_gate_r <= IOCF_RST_OUT_GATE; // RULE11
			pri_cmd_r <= IOCF_RST_OUT_CMD;
			sec_cmd_r <= IOCF_RST_OUT_CMD;
		end
		else if (wr_en)
		begin
			case (paddr)
				IOCF_ADDR_PRI_DIR: pri_dir_r <= pwdata[7:0];
				IOCF_ADDR_SEC_DIR: sec_dir_r <= pwdata[7:0];
				IOCF_ADDR_DIAG_SEL: diag_sel_r <= pwdata[7:0];
				IOCF_ADDR_IN_MASK: in_mask_r <= pwdata[7:0];
				IOCF_ADDR_FB_MODE: fb_mode_r <= pwdata[7:0];
				IOCF_ADDR_FB_STATE: fb_state_r <= pwdata[7:0];
				IOCF_ADDR_OUT_GATE: out_gate_r <= pwdata[7:0];
				IOCF_ADDR_OUT_CMD:
				begin
					pri_cmd_r <= pwdata[7:0];
					sec_cmd_r <= pwdata[15:8];
				end
				default: ;
			endcase
		end
	end

	// Stop wins over fallback so an online stop never disturbs outputs
	always_comb
	begin
		mode_nxt = IOCF_RUN;
		if (cfg_stop)
			mode_nxt = IOCF_FREEZE; // RULE13
		else if (fb_event)
			mode_nxt = IOCF_FALLBACK; // RULE7 RULE12
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			mode_r <= IOCF_RUN;
		else
		begin
			case (mode_nxt)
				IOCF_RUN: mode_r <= IOCF_RUN; // RULE16
				IOCF_FALLBACK: mode_r <= IOCF_FALLBACK;
				IOCF_FREEZE: mode_r <= IOCF_FREEZE;
				default: mode_r <= IOCF_RUN;
			endcase
		end
	end

	// Output values lag the mode by one edge; the mode itself is registered
	genvar g;
	generate
		for (g = 0; g < CH; g++)
		begin : g_ch
			iocf_out_chan u_pri
			(
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.fallback(mode_r == IOCF_FALLBACK),
				.freeze(mode_r == IOCF_FREEZE),
				.cmd(pri_cmd_r[g]),
				.gate(out_gate_r[g]),
				.fb_mode(fb_mode_r[g]),
				.fb_state(fb_state_r[g]),
				.q(pri_q[g])
			);
			iocf_out_chan u_sec
			(
				.clk_sys(clk_sys),
				.rst_n(rst_n),
				.fallback(mode_r == IOCF_FALLBACK),
				.freeze(mode_r == IOCF_FREEZE),
				.cmd(sec_cmd_r[g]),
				.gate(out_gate_r[g]),
				.fb_mode(fb_mode_r[g]),
				.fb_state(fb_state_r[g]),
				.q(sec_q[g])
			);
		end
	endgenerate

	// Pins drive only where configured as outputs
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pri_out <= '0;
			pri_oe <= '0;
			sec_out <= '0;
			sec_oe <= '0;
			fallback_active <= 1'b0;
		end
		else
		begin
			pri_oe <= pri_dir_r; // RULE1
			pri_out <= pri_q & pri_dir_r; // RULE1
			sec_oe <= sec_is_out;
			sec_out <= sec_q & sec_is_out;
			fallback_active <= (mode_r == IOCF_FALLBACK);
		end
	end

	// Input image: input data words first, then one diagnostic word, then outputs, diag select and mode
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < IOCF_IMAGE_WORDS; i++)
				image_r[i] <= 16'h0000;
		end
		else
		begin
			image_r[0] <= {8'h00, pri_in & ~pri_dir_r & ~in_mask_r}; // RULE14 RULE5
			image_r[1] <= {8'h00, sec_in & sec_is_in & ~in_mask_r}; // RULE14 RULE2
			image_r[2] <= {8'h00, diag_in & diag_sel_r & ~in_mask_r}; // RULE14 RULE4 RULE6
			image_r[3] <= {8'h00, pri_q & pri_dir_r};
			image_r[4] <= {8'h00, sec_q & sec_is_out};
			image_r[5] <= {8'h00, diag_sel_r};
			image_r[6] <= {13'h0000, mode_r};
			image_r[7] <= 16'h0000;
		end
	end

	// Read mux; unmapped addresses answer with an error
	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		addr_ok = 1'b1;
		case (paddr)
			IOCF_ADDR_PRI_DIR: rd_nxt = {24'h000000, pri_dir_r};
			IOCF_ADDR_SEC_DIR: rd_nxt = {24'h000000, sec_dir_r};
			IOCF_ADDR_DIAG_SEL: rd_nxt = {24'h000000, diag_sel_r};
			IOCF_ADDR_IN_MASK: rd_nxt = {24'h000000, in_mask_r};
			IOCF_ADDR_FB_MODE: rd_nxt = {24'h000000, fb_mode_r};
			IOCF_ADDR_FB_STATE: rd_nxt = {24'h000000, fb_state_r};
			IOCF_ADDR_OUT_GATE: rd_nxt = {24'h000000, out_gate_r};
			IOCF_ADDR_OUT_CMD: rd_nxt = {16'h0000, sec_cmd_r, pri_cmd_r};
			IOCF_ADDR_STATUS: rd_nxt = {30'h0, mode_r == IOCF_FREEZE, mode_r == IOCF_FALLBACK};
			default:
			begin
				if (paddr[7:5] == IOCF_ADDR_IMAGE[7:5])
					rd_nxt = {16'h0000, image_r[paddr[4:2]]}; // RULE14
				else
					addr_ok = 1'b0;
			end
		endcase
	end

	// Answer comes one edge after the setup cycle
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok;
			if (psel && !penable && !pwrite)
				prdata <= rd_nxt;
		end
	end

	property p_fb_pred;
		@(posedge clk_sys) disable iff (!rst_n)
		(mode_r == IOCF_FALLBACK) && fb_mode_r[0] && pri_dir_r[0] ##1 (mode_r == IOCF_FALLBACK) && $stable(fb_state_r[0])
		|=> pri_out[0] == fb_state_r[0];
	endproperty
	a_fb_pred: assert property (p_fb_pred) else $error("predefined fallback not driven"); // RULE10

	property p_fb_hold;
		@(posedge clk_sys) disable iff (!rst_n)
		(mode_r == IOCF_FALLBACK) && !fb_mode_r[0] && $stable(pri_dir_r) |=> $stable(pri_q[0]);
	endproperty
	a_fb_hold: assert property (p_fb_hold) else $error("hold fallback changed output"); // RULE9

	property p_freeze;
		@(posedge clk_sys) disable iff (!rst_n)
		(mode_r == IOCF_FREEZE) |=> $stable(pri_q) && $stable(sec_q);
	endproperty
	a_freeze: assert property (p_freeze) else $error("outputs moved under stop"); // RULE13

	property p_event;
		@(posedge clk_sys) disable iff (!rst_n)
		fb_event && !cfg_stop |=> mode_r == IOCF_FALLBACK ##1 fallback_active;
	endproperty
	a_event: assert property (p_event) else $error("event did not enter fallback"); // RULE7

	property p_gate_off;
		@(posedge clk_sys) disable iff (!rst_n)
		(mode_r == IOCF_RUN) && !out_gate_r[0] |=> $stable(pri_q[0]);
	endproperty
	a_gate_off: assert property (p_gate_off) else $error("gated output moved"); // RULE11

	property p_resume;
		@(posedge clk_sys) disable iff (!rst_n)
		(mode_r == IOCF_RUN) && out_gate_r[0] |=> pri_q[0] == $past(pri_cmd_r[0]);
	endproperty
	a_resume: assert property (p_resume) else $error("command not applied"); // RULE16

	property p_pri_dir;
		@(posedge clk_sys) disable iff (!rst_n)
		##1 pri_oe == $past(pri_dir_r);
	endproperty
	a_pri_dir: assert property (p_pri_dir) else $error("primary enable wrong"); // RULE1

	property p_sec_in;
		@(posedge clk_sys) disable iff (!rst_n)
		(diag_sel_r[0] || sec_dir_r[0]) |=> !image_r[1][0];
	endproperty
	a_sec_in: assert property (p_sec_in) else $error("secondary input leaked"); // RULE2

	property p_mask;
		@(posedge clk_sys) disable iff (!rst_n)
		in_mask_r[0] |=> !image_r[0][0] && !image_r[2][0];
	endproperty
	a_mask: assert property (p_mask) else $error("masked input reported"); // RULE5 RULE6

	property p_sec_dir;
		@(posedge clk_sys) disable iff (!rst_n)
		##1 sec_oe == $past(sec_is_out);
	endproperty
	a_sec_dir: assert property (p_sec_dir) else $error("secondary enable wrong"); // RULE2

	property p_diag_off;
		@(posedge clk_sys) disable iff (!rst_n)
		!diag_sel_r[0] |=> !image_r[2][0];
	endproperty
	a_diag_off: assert property (p_diag_off) else $error("diagnostic reported while deselected"); // RULE4

	property p_stop_wins;
		@(posedge clk_sys) disable iff (!rst_n)
		cfg_stop |=> mode_r == IOCF_FREEZE;
	endproperty
	a_stop_wins: assert property (p_stop_wins) else $error("stop did not freeze outputs"); // RULE13

	c_fallback: cover property (@(posedge clk_sys) disable iff (!rst_n) mode_r == IOCF_FALLBACK ##1 mode_r == IOCF_RUN);
	c_freeze: cover property (@(posedge clk_sys) disable iff (!rst_n) mode_r == IOCF_FREEZE);
	c_hold: cover property (@(posedge clk_sys) disable iff (!rst_n) (mode_r == IOCF_FALLBACK) && !fb_mode_r[0]);
	c_write: cover property (@(posedge clk_sys) disable iff (!rst_n) wr_en && pready);
	c_read: cover property (@(posedge clk_sys) disable iff (!rst_n) rd_en && pready && !pslverr);
endmodule
`default_nettype wire

// ### verification/iocf_nim_model.sv
// Network interface side model: an APB master that relays commands.
// Assumes one clock and a slave that raises pready once per access phase.
`timescale 1ns/1ps
`default_nettype none
module iocf_netif_model
(
	// Clock
	input wire logic clk_sys,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end
	// Image placement by node address is kept outside this block; the model reads word offsets only
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] dw, output logic [31:0] dr, output logic e);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= dw;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		dr = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Self-checking bench for the channel configuration and fallback block.
// Assumes the network interface model as APB master and the bench driving pins and events.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import iocf_pkg::*;
	logic clk_sys, rst_n;
	logic psel, penable, pwrite, pready, pslverr, fallback_active;
	logic [7:0] paddr, pri_in, sec_in, diag_in, pri_out, pri_oe, sec_out, sec_oe;
	logic [31:0] pwdata, prdata, rd;
	logic [6:0] evt;
	logic e;
	int err_count, tests_run;
	logic [7:0] rst_v [7];
	iocf_netif_model i_netif (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
	iocf_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.link_lost(evt[0]), .netif_fail(evt[1]), .cable_off(evt[2]), .cfg_download(evt[3]), .cfg_reset(evt[4]),
		.cfg_store(evt[5]), .cfg_stop(evt[6]), .pri_in(pri_in), .pri_out(pri_out), .pri_oe(pri_oe),
		.sec_in(sec_in), .sec_out(sec_out), .sec_oe(sec_oe), .diag_in(diag_in),
		.fallback_active(fallback_active));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		i_netif.xfer(1'b1, a, d, rd, e);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] exp);
		i_netif.xfer(1'b0, a, 32'h00000000, rd, e);
		chk(rd, exp);
	endtask
	// Event to pin takes three edges; pins are read at the falling edge, well away from updates
	task settle;
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// Events change only just after a rising edge, like every other pin input
	task set_evt(input logic [6:0] v);
		@(posedge clk_sys);
		evt <= v;
	endtask
	task results;
		$display("Mismatches %0d, comparisons %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		err_count++;
		results;
	end
	initial
	begin
		rst_n = 1'b0;
		evt = 7'h00;
		pri_in = 8'h00;
		sec_in = 8'h00;
		diag_in = 8'h00;
		err_count = 0;
		tests_run = 0;
		rst_v = '{IOCF_RST_PRI_DIR, IOCF_RST_SEC_DIR, IOCF_RST_DIAG_SEL, IOCF_RST_IN_MASK,
			IOCF_RST_FB_MODE, IOCF_RST_FB_STATE, IOCF_RST_OUT_GATE};
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++)
			rdc(8'(4 * i), {24'h0, rst_v[i]});
		chk({24'h0, pri_oe}, 32'h0);
		chk({24'h0, sec_oe}, 32'h0);
		i_netif.xfer(1'b0, 8'h30, 32'h0, rd, e);
		chk({31'h0, e}, 32'h1);
		chk(rd, 32'h0);
		// Inputs, masking and diagnostics
		pri_in <= 8'hA5;
		diag_in <= 8'hFF;
		sec_in <= 8'h3C;
		wr(IOCF_ADDR_IN_MASK, 32'h0F);
		settle;
		rdc(IOCF_ADDR_IMAGE, 32'hA0);
		rdc(IOCF_ADDR_IMAGE + 8'h08, 32'hF0);
		wr(IOCF_ADDR_DIAG_SEL, 32'h00);
		settle;
		rdc(IOCF_ADDR_IMAGE + 8'h08, 32'h00);
		rdc(IOCF_ADDR_IMAGE + 8'h04, 32'h30);
		wr(IOCF_ADDR_IN_MASK, 32'h00);
		// Outputs and fallback per event
		wr(IOCF_ADDR_PRI_DIR, 32'hFF);
		wr(IOCF_ADDR_OUT_CMD, 32'h5A);
		wr(IOCF_ADDR_FB_MODE, 32'h0F);
		wr(IOCF_ADDR_FB_STATE, 32'h35);
		settle;
		chk({24'h0, pri_oe}, 32'hFF);
		chk({24'h0, pri_out}, 32'h5A);
		// Low nibble predefined, high nibble holds the commanded value
		for (int i = 0; i < 6; i++)
		begin
			set_evt(7'(1 << i));
			settle;
			chk({24'h0, pri_out}, 32'h55);
			chk({31'h0, fallback_active}, 32'h1);
			set_evt(7'h00);
			settle;
			chk({24'h0, pri_out}, 32'h5A);
		end
		// Swapped modes: low nibble holds, high nibble takes the predefined state
		wr(IOCF_ADDR_FB_MODE, 32'hF0);
		set_evt(7'h01);
		settle;
		chk({24'h0, pri_out}, 32'h3A);
		set_evt(7'h00);
		settle;
		chk({24'h0, pri_out}, 32'h5A);
		// Secondary pins as outputs once diagnostics are off
		wr(IOCF_ADDR_SEC_DIR, 32'hFF);
		wr(IOCF_ADDR_OUT_CMD, 32'hC35A);
		settle;
		chk({24'h0, sec_oe}, 32'hFF);
		chk({24'h0, sec_out}, 32'hC3);
		rdc(IOCF_ADDR_IMAGE + 8'h10, 32'hC3);
		rdc(IOCF_ADDR_IMAGE + 8'h04, 32'h00);
		// Gate closed on low nibble holds it
		wr(IOCF_ADDR_OUT_GATE, 32'hF0);
		wr(IOCF_ADDR_OUT_CMD, 32'hF5);
		settle;
		chk({24'h0, pri_out}, 32'hFA);
		chk({24'h0, sec_out}, 32'h03);
		// Stop with a fallback event keeps last states
		set_evt(7'h41);
		settle;
		chk({24'h0, pri_out}, 32'hFA);
		chk({24'h0, sec_out}, 32'h03);
		chk({31'h0, fallback_active}, 32'h0);
		rdc(IOCF_ADDR_STATUS, 32'h2);
		set_evt(7'h00);
		settle;
		chk({24'h0, pri_out}, 32'hFA);
		results;
	end
endmodule
`default_nettype wire
